//--- rtl/acq_pkg.sv
// Shared constants and types for the snapshot acquisition sequencer, plus its sampling clock.
`timescale 1ns/100ps
package acq_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_COMMAND   = 8'h00;
  localparam logic [7:0] OFS_STORAGE   = 8'h04;
  localparam logic [7:0] OFS_ON_TIME   = 8'h08;
  localparam logic [7:0] OFS_OFF_TIME  = 8'h0C;
  localparam logic [7:0] OFS_ACQ_STAT  = 8'h10;
  localparam logic [7:0] OFS_CUR_ADDR  = 8'h14;
  localparam logic [7:0] OFS_END_ADDR  = 8'h18;
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h1C;
  localparam logic [7:0] OFS_IRQ_MASK  = 8'h20;

  // Command codes written to the command register
  localparam logic [3:0] select_increment_storage = 4'h1;
  localparam logic [3:0] select_accumulate_storage = 4'h2;
  localparam logic [3:0] start_gate_level_acq     = 4'h3;
  localparam logic [3:0] start_gate_edge_acq      = 4'h4;
  localparam logic [3:0] start_clock_sync_acq     = 4'h5;
  localparam logic [3:0] stop_acq                 = 4'h6;

  // Storage type answers
  localparam logic [31:0] raw_value_code       = 32'h0000_0000;
  localparam logic [31:0] increment_value_code = 32'h0000_0001;

  // Acquisition status answers
  localparam logic [31:0] STAT_OFF        = 32'h0000_0000;
  localparam logic [31:0] STAT_GATE_LEVEL = 32'h0000_0001;
  localparam logic [31:0] STAT_TIMER_GATE = 32'h0000_0002;
  localparam logic [31:0] STAT_GATE_EDGE  = 32'h0000_0003;
  localparam logic [31:0] STAT_HEX_CONV   = 32'h0000_0004;

  // Interrupt status bit positions
  localparam int IRQ_SAMPLE_BIT = 0;
  localparam int IRQ_DONE_BIT   = 1;
  localparam int IRQ_W          = 2;

  // Reset values
  localparam logic [31:0] ON_TIME_RST  = 32'h0000_0001;
  localparam logic [31:0] OFF_TIME_RST = 32'h0000_0001;

  // Timing
  localparam int CLK_NS       = 50;
  localparam int US_NS        = 1000;
  localparam int CYC_PER_US   = US_NS / CLK_NS;
  localparam int OFF_ZERO_NS  = 200;
  localparam int OFF_ZERO_CYC = (OFF_ZERO_NS + CLK_NS - 1) / CLK_NS;
  localparam int PRE_W        = 5;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_LEVEL = 4'b0010,
    ST_EDGE  = 4'b0100,
    ST_CLOCK = 4'b1000
  } acq_state_e;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } bus_req_s;
endpackage : acq_pkg

////////////////////////////////////////////////////////////////////////////////
module sample_clock_gen
  import acq_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  // Control
  input  wire logic        run_in,
  input  wire logic [31:0] on_us_in,
  input  wire logic [31:0] off_us_in,
  // Phase
  output logic             phase_on_out,
  output logic             on_end_out
);
  localparam logic [PRE_W-1:0] PRE_LAST  = PRE_W'(CYC_PER_US - 1);
  localparam logic [PRE_W-1:0] ZERO_LAST = PRE_W'(OFF_ZERO_CYC - 1);

  logic [PRE_W-1:0] pre_q;
  logic [31:0]      us_q;
  logic             run_q;
  logic             us_tick;
  logic             on_done;
  logic             off_done;

  assign us_tick  = (pre_q == PRE_LAST);
  // Zero on-time would never end; it acts as the shortest legal setting
  assign on_done  = us_tick && ({1'b0, us_q} + 33'd1 >= {1'b0, on_us_in});
  assign off_done = (off_us_in == 32'h0) ? (pre_q == ZERO_LAST)
                  : (us_tick && ({1'b0, us_q} + 33'd1 >= {1'b0, off_us_in}));

  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      pre_q        <= '0;
      us_q         <= '0;
      run_q        <= 1'b0;
      phase_on_out <= 1'b0;
      on_end_out   <= 1'b0;
    end
    else
    begin
      run_q      <= run_in;
      on_end_out <= 1'b0;
      if (!run_in || !run_q)
      begin
        pre_q        <= '0;
        us_q         <= '0;
        phase_on_out <= run_in;
      end
      else if (phase_on_out ? on_done : off_done)
      begin
        pre_q        <= '0;
        us_q         <= '0;
        phase_on_out <= !phase_on_out;
        on_end_out   <= phase_on_out;
      end
      else
      begin
        pre_q <= us_tick ? '0 : pre_q + 1'b1;
        us_q  <= us_tick ? us_q + 32'd1 : us_q;
      end
    end
  end
endmodule : sample_clock_gen

//--- rtl/sync_counter_snapshot_acq.sv
// Acquisition sequencer storing counter and timer snapshots on gate or internal clock.
//
// Functional notes
// - After reset, raw accumulated counts are stored until increment storage is chosen.
// - Increment mode stores present count minus that channel's count at previous sample, or at the start command for the first sample.
// - Accumulation mode stores the counter value unchanged at the sampling instant.
// - Storage type query answers raw or increment code.
// - Gate-level start stores gate-synchronous samples up to end address; idle at reset.
// - Gate-edge start opens counting at first falling edge; samples on later falls.
// - Clock-sync start stores samples on internal clock up to end address; idle at reset.
// - Internal sampling clock alternates programmed on and off periods.
// - In clock-sync mode counting needs both internal clock and external gate on.
// - On-time accepted in microseconds 1 to 4294967295 and read back.
// - Off-time same range; zero gives about 200 ns off period.
// - Off-time reads back in microseconds.
// - Stop command halts counting at once and ends any acquisition.
// - Status query reports active mode, or inactive when none runs.
// - Status reports conversion in progress after acquisition until conversion ends.
// - Acquisition stops automatically when current address reaches end address.
// - Gate-level mode counts while gate high, stores sample at each falling edge.
`timescale 1ns/100ps
module sync_counter_snapshot_acq
  import acq_pkg::*;
#(
  parameter int N_CH   = 8,
  parameter int CNT_W  = 32,
  parameter int ADDR_W = 14
)
(
  // Clock and reset
  input  wire logic                        clk_in,
  input  wire logic                        sys_rst_in,
  // Register port
  input  wire bus_req_s                    bus_in,
  output logic [31:0]                      rd_data_out,
  // Gate pin and counter values (index N_CH is the timer)
  input  wire logic                        gate_in,
  input  wire logic [N_CH:0][CNT_W-1:0]    counts_in,
  input  wire logic                        hex_conv_busy_in,
  // Counter gating and sample memory write
  output logic                             count_en_out,
  output logic                             mem_we_out,
  output logic [ADDR_W-1:0]                mem_addr_out,
  output logic [N_CH:0][CNT_W-1:0]         mem_data_out,
  // Interrupt
  output logic                             irq_out
);
  ////////////////////////////////////////////////////////////////////////////
  // Register access decode
  logic       cmd_wr;
  logic [3:0] cmd;

  assign cmd_wr = bus_in.wr && (bus_in.addr == OFS_COMMAND);
  assign cmd    = bus_in.wdata[3:0];

  ////////////////////////////////////////////////////////////////////////////
  // Gate pin synchroniser: a change counts once the second and third stages agree
  logic [2:0] gate_sync_q;
  logic       gate_lvl_q;
  logic       gate_prev_q;
  logic       gate_fall;

  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      gate_sync_q <= 3'h0;
      gate_lvl_q  <= 1'b0;
      gate_prev_q <= 1'b0;
    end
    else
    begin
      gate_sync_q <= {gate_sync_q[1:0], gate_in};
      if (gate_sync_q[1] == gate_sync_q[2])
      begin
        gate_lvl_q <= gate_sync_q[2];
      end
      gate_prev_q <= gate_lvl_q;
    end
  end

  assign gate_fall = gate_prev_q && !gate_lvl_q;

  ////////////////////////////////////////////////////////////////////////////
  // Software settings
  logic              inc_mode_q;
  logic [31:0]       on_us_q;
  logic [31:0]       off_us_q;
  logic [ADDR_W-1:0] end_addr_q;

  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      inc_mode_q <= 1'b0;
    end
    else if (cmd_wr && cmd == select_increment_storage)
    begin
      inc_mode_q <= 1'b1;
    end
    else if (cmd_wr && cmd == select_accumulate_storage)
    begin
      inc_mode_q <= 1'b0;
    end
  end

  // Times are taken as written; any 32-bit microsecond figure is legal
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      on_us_q    <= ON_TIME_RST;
      off_us_q   <= OFF_TIME_RST;
      end_addr_q <= '0;
    end
    else if (bus_in.wr)
    begin
      if (bus_in.addr == OFS_ON_TIME)
      begin
        on_us_q <= bus_in.wdata;
      end
      if (bus_in.addr == OFS_OFF_TIME)
      begin
        off_us_q <= bus_in.wdata;
      end
      if (bus_in.addr == OFS_END_ADDR)
      begin
        end_addr_q <= bus_in.wdata[ADDR_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Internal sampling clock
  acq_state_e        state_q;
  acq_state_e        state_d;
  logic              clk_phase_on;
  logic              clk_on_end;

  sample_clock_gen u_clk_gen (
    .clk_in       (clk_in),
    .sys_rst_in   (sys_rst_in),
    .run_in       (state_q == ST_CLOCK),
    .on_us_in     (on_us_q),
    .off_us_in    (off_us_q),
    .phase_on_out (clk_phase_on),
    .on_end_out   (clk_on_end)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Acquisition sequencer
  logic              edge_open_q;
  logic [ADDR_W-1:0] cur_addr_q;
  logic              sample_fire;
  logic              last_sample;
  logic              start_cmd;

  assign start_cmd = cmd_wr && (cmd == start_gate_level_acq || cmd == start_gate_edge_acq
                               || cmd == start_clock_sync_acq);

  always_comb
  begin
    sample_fire = 1'b0;
    case (state_q)
      ST_LEVEL: sample_fire = gate_fall;
      ST_EDGE:  sample_fire = gate_fall && edge_open_q;
      ST_CLOCK: sample_fire = clk_on_end;
      default:  sample_fire = 1'b0;
    endcase
  end

  assign last_sample = sample_fire && (cur_addr_q == end_addr_q);

  always_comb
  begin
    state_d = state_q;
    if (cmd_wr && cmd == stop_acq)
    begin
      state_d = ST_IDLE;
    end
    else if (last_sample)
    begin
      state_d = ST_IDLE;
    end
    else if (state_q == ST_IDLE && start_cmd)
    begin
      case (cmd)
        start_gate_level_acq: state_d = ST_LEVEL;
        start_gate_edge_acq:  state_d = ST_EDGE;
        start_clock_sync_acq: state_d = ST_CLOCK;
        default:              state_d = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      state_q <= ST_IDLE;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // Gate-edge mode waits for a first falling edge before counting
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      edge_open_q <= 1'b0;
    end
    else if (state_q != ST_EDGE)
    begin
      edge_open_q <= 1'b0;
    end
    else if (gate_fall)
    begin
      edge_open_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      cur_addr_q <= '0;
    end
    else if (sample_fire)
    begin
      cur_addr_q <= cur_addr_q + 1'b1;
    end
    else if (bus_in.wr && bus_in.addr == OFS_CUR_ADDR)
    begin
      cur_addr_q <= bus_in.wdata[ADDR_W-1:0];
    end
  end

  // Counter gate follows the mode one cycle behind its cause
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      count_en_out <= 1'b0;
    end
    else
    begin
      case (state_d)
        ST_LEVEL: count_en_out <= gate_lvl_q;
        ST_EDGE:  count_en_out <= edge_open_q || gate_fall;
        ST_CLOCK: count_en_out <= clk_phase_on && gate_lvl_q;
        default:  count_en_out <= 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Snapshot path, one lane per channel and the timer
  logic [N_CH:0][CNT_W-1:0] prev_q;

  for (genvar ch = 0; ch <= N_CH; ch++)
  begin : g_lane
    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
      if (sys_rst_in)
      begin
        prev_q[ch]       <= '0;
        mem_data_out[ch] <= '0;
      end
      else if (state_q == ST_IDLE && start_cmd)
      begin
        prev_q[ch] <= counts_in[ch];
      end
      else if (sample_fire)
      begin
        prev_q[ch]       <= counts_in[ch];
        mem_data_out[ch] <= inc_mode_q ? counts_in[ch] - prev_q[ch]
                                       : counts_in[ch];
      end
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      mem_we_out   <= 1'b0;
      mem_addr_out <= '0;
    end
    else
    begin
      mem_we_out <= sample_fire;
      if (sample_fire)
      begin
        mem_addr_out <= cur_addr_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts: set wins over a write-one clear
  logic [IRQ_W-1:0] irq_stat_q;
  logic [IRQ_W-1:0] irq_mask_q;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;

  assign irq_set = {state_q != ST_IDLE && state_d == ST_IDLE, sample_fire};
  assign irq_clr = (bus_in.wr && bus_in.addr == OFS_IRQ_STAT) ? bus_in.wdata[IRQ_W-1:0] : '0;

  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      irq_stat_q <= '0;
      irq_mask_q <= '0;
      irq_out    <= 1'b0;
    end
    else
    begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
      if (bus_in.wr && bus_in.addr == OFS_IRQ_MASK)
      begin
        irq_mask_q <= bus_in.wdata[IRQ_W-1:0];
      end
      irq_out <= |(((irq_stat_q & ~irq_clr) | irq_set) & irq_mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read back
  logic [31:0] status_code;
  logic [31:0] rd_mux;

  always_comb
  begin
    case (state_q)
      ST_LEVEL: status_code = STAT_GATE_LEVEL;
      ST_CLOCK: status_code = STAT_TIMER_GATE;
      ST_EDGE:  status_code = STAT_GATE_EDGE;
      default:  status_code = hex_conv_busy_in ? STAT_HEX_CONV : STAT_OFF;
    endcase
  end

  always_comb
  begin
    case (bus_in.addr)
      OFS_STORAGE:  rd_mux = inc_mode_q ? increment_value_code : raw_value_code;
      OFS_ON_TIME:  rd_mux = on_us_q;
      OFS_OFF_TIME: rd_mux = off_us_q;
      OFS_ACQ_STAT: rd_mux = status_code;
      OFS_CUR_ADDR: rd_mux = 32'(cur_addr_q);
      OFS_END_ADDR: rd_mux = 32'(end_addr_q);
      OFS_IRQ_STAT: rd_mux = 32'(irq_stat_q);
      OFS_IRQ_MASK: rd_mux = 32'(irq_mask_q);
      default:      rd_mux = 32'h0000_0000;
    endcase
  end

  // Data stand only in the cycle after the read strobe
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      rd_data_out <= 32'h0000_0000;
    end
    else
    begin
      rd_data_out <= bus_in.rd ? rd_mux : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  store_type_a: assert property ($changed(inc_mode_q) |-> $past(cmd_wr))
    else $error("storage type changed without a command");
  incr_value_a: assert property (sample_fire && inc_mode_q
      |=> mem_data_out[0] == $past(counts_in[0]) - $past(prev_q[0]))
    else $error("increment sample wrong");
  raw_value_a: assert property (sample_fire && !inc_mode_q
      |=> mem_data_out[0] == $past(counts_in[0]))
    else $error("raw sample wrong");
  type_query_a: assert property (bus_in.rd && bus_in.addr == OFS_STORAGE
      |=> rd_data_out == ($past(inc_mode_q) ? increment_value_code : raw_value_code))
    else $error("storage type answer wrong");
  level_gate_a: assert property (state_q == ST_LEVEL && state_d == ST_LEVEL
      |=> count_en_out == $past(gate_lvl_q))
    else $error("gate-level counting wrong");
  edge_sample_a: assert property (state_q == ST_EDGE && edge_open_q && gate_fall
      |=> mem_we_out ##0 (count_en_out == (state_q == ST_EDGE)))
    else $error("gate-edge sample missing");
  clock_gate_a: assert property (state_q == ST_CLOCK && state_d == ST_CLOCK
      && !(clk_phase_on && gate_lvl_q) |=> !count_en_out)
    else $error("clock-gated counting without both gates");
  stop_halt_a: assert property (cmd_wr && cmd == stop_acq
      |=> state_q == ST_IDLE && !count_en_out ##1 !mem_we_out)
    else $error("stop did not halt");
  end_stop_a: assert property (last_sample |=> state_q == ST_IDLE && mem_we_out)
    else $error("no stop at end address");
  status_idle_a: assert property (bus_in.rd && bus_in.addr == OFS_ACQ_STAT && state_q == ST_IDLE
      && !hex_conv_busy_in |=> rd_data_out == STAT_OFF)
    else $error("idle status wrong");
endmodule : sync_counter_snapshot_acq

//--- sim/count_bank.sv
// Behavioural counter bank standing in for the channel counters and timer.
`timescale 1ns/100ps
module count_bank #(
  parameter int N_CH  = 8,
  parameter int CNT_W = 32
)
(
  // Clock and reset
  input  wire logic                     clk_in,
  input  wire logic                     sys_rst_in,
  // Gate from the sequencer
  input  wire logic                     count_en_in,
  // Counter values, index N_CH is the timer
  output logic [N_CH:0][CNT_W-1:0]      counts_out
);
  // Channel i steps by i+1 so every sample must hold channel i = (i+1) * timer
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      counts_out <= '0;
    else if (count_en_in)
      for (int i = 0; i <= N_CH; i++)
        counts_out[i] <= counts_out[i] + CNT_W'((i == N_CH) ? 1 : i + 1);
  end
endmodule : count_bank

//--- sim/sync_counter_snapshot_acq_bench.sv
// Self-checking bench for the snapshot acquisition sequencer.
`timescale 1ns/100ps
module sync_counter_snapshot_acq_bench;
  import acq_pkg::*;
  localparam int N_CH = 8;
  logic                   clk_in;
  logic                   sys_rst_in;
  logic                   gate_q;
  logic                   busy_q;
  bus_req_s               bus_q;
  logic [31:0]            rd_data;
  logic [N_CH:0][31:0]    counts;
  logic [N_CH:0][31:0]    mem_data;
  logic                   count_en;
  logic                   mem_we;
  logic                   irq;
  logic [13:0]            mem_addr;
  logic [31:0]            rv;
  logic [31:0]            s_t[$];
  logic [13:0]            s_a[$];
  int                     s_c[$];
  int                     mismatches;
  int                     checks_done;
  int                     cycle;
  int                     k;

  initial
  begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end

  sync_counter_snapshot_acq #(.N_CH(N_CH), .CNT_W(32), .ADDR_W(14)) i_dut (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .bus_in(bus_q), .rd_data_out(rd_data),
    .gate_in(gate_q), .counts_in(counts), .hex_conv_busy_in(busy_q),
    .count_en_out(count_en), .mem_we_out(mem_we), .mem_addr_out(mem_addr),
    .mem_data_out(mem_data), .irq_out(irq));

  count_bank #(.N_CH(N_CH), .CNT_W(32)) i_bank (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .count_en_in(count_en), .counts_out(counts));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wrap_up;
    $display("Checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    bus_q <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_in);
    bus_q <= '0;
    #1;
  endtask : wr

  // Read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rd(input logic [7:0] a);
    @(posedge clk_in);
    bus_q <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge clk_in);
    bus_q <= '0;
    #1;
    rv = rd_data;
  endtask : rd

  task automatic cmd(input logic [3:0] c);
    wr(OFS_COMMAND, {28'h0, c});
  endtask : cmd

  task automatic pulse(input int hi, input int lo);
    @(posedge clk_in);
    gate_q <= 1'b1;
    repeat (hi) @(posedge clk_in);
    gate_q <= 1'b0;
    repeat (lo - 1) @(posedge clk_in);
  endtask : pulse

  // Bounded wait, then a quiet stretch so an overrun would show up in the count
  task automatic wait_samples(input int n);
    k = 0;
    while (s_t.size() < n && k < 3000)
    begin
      @(posedge clk_in);
      k++;
    end
    repeat (60) @(posedge clk_in);
    #1;
  endtask : wait_samples

  task automatic setup(input logic [31:0] cur, input logic [31:0] last);
    wr(OFS_CUR_ADDR, cur);
    wr(OFS_END_ADDR, last);
    s_t.delete();
    s_a.delete();
    s_c.delete();
  endtask : setup

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_in)
  begin
    cycle++;
    if (cycle >= 20000)
    begin
      mismatches++;
      wrap_up();
    end
    else if (mem_we === 1'b1)
    begin
      s_t.push_back(mem_data[N_CH]);
      s_a.push_back(mem_addr);
      s_c.push_back(cycle);
      for (int i = 0; i < N_CH; i++)
        check("channel ratio", mem_data[i], mem_data[N_CH] * (i + 1));
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    sys_rst_in = 1'b1;
    bus_q = '0;
    gate_q = 1'b0;
    busy_q = 1'b0;
    mismatches = 0;
    checks_done = 0;
    cycle = 0;
    repeat (5) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    rd(OFS_STORAGE);
    check("storage type", rv, raw_value_code);
    rd(OFS_ACQ_STAT);
    check("status", rv, STAT_OFF);
    rd(OFS_ON_TIME);
    check("on time", rv, ON_TIME_RST);
    rd(8'h24);
    check("unmapped", rv, 32'h0);
    busy_q <= 1'b1;
    rd(OFS_ACQ_STAT);
    check("status", rv, STAT_HEX_CONV);
    busy_q <= 1'b0;
    rd(OFS_ACQ_STAT);
    check("status", rv, STAT_OFF);
    $display("Test reset done");

    wr(OFS_IRQ_MASK, 32'h3);
    setup(2, 4);
    cmd(start_gate_level_acq);
    rd(OFS_ACQ_STAT);
    check("status", rv, STAT_GATE_LEVEL);
    cmd(start_gate_edge_acq);
    rd(OFS_ACQ_STAT);
    check("status", rv, STAT_GATE_LEVEL);
    repeat (3) pulse(10, 10);
    wait_samples(3);
    check("samples", s_t.size(), 3);
    for (int i = 0; i < 3; i++)
      check("address", {18'h0, s_a[i]}, 32'(2 + i));
    check("accumulate step", s_t[2] - s_t[1], s_t[1] - s_t[0]);
    check("accumulate grows", 32'(s_t[2] > s_t[1]), 32'h1);
    rd(OFS_ACQ_STAT);
    check("status", rv, STAT_OFF);
    check("irq", {31'h0, irq}, 32'h1);
    rd(OFS_IRQ_STAT);
    check("irq status", rv, 32'h3);
    wr(OFS_IRQ_MASK, 32'h0);
    @(posedge clk_in);
    #1;
    check("irq masked", {31'h0, irq}, 32'h0);
    wr(OFS_IRQ_STAT, 32'h3);
    wr(OFS_IRQ_MASK, 32'h3);
    rd(OFS_IRQ_STAT);
    check("irq status", rv, 32'h0);
    check("irq", {31'h0, irq}, 32'h0);
    $display("Test gate level done");

    cmd(select_increment_storage);
    rd(OFS_STORAGE);
    check("storage type", rv, increment_value_code);
    setup(0, 2);
    cmd(start_gate_edge_acq);
    rd(OFS_ACQ_STAT);
    check("status", rv, STAT_GATE_EDGE);
    repeat (10) @(posedge clk_in);
    #1;
    check("count enable", {31'h0, count_en}, 32'h0);
    pulse(10, 10);
    #1;
    check("count enable", {31'h0, count_en}, 32'h1);
    check("samples", s_t.size(), 0);
    repeat (3) pulse(10, 10);
    wait_samples(3);
    check("samples", s_t.size(), 3);
    check("increment", s_t[2], s_t[1]);
    check("increment nonzero", 32'(s_t[1] != 0), 32'h1);
    $display("Test gate edge done");

    cmd(select_accumulate_storage);
    rd(OFS_STORAGE);
    check("storage type", rv, raw_value_code);
    wr(OFS_ON_TIME, 32'hFFFF_FFFF);
    rd(OFS_ON_TIME);
    check("on time", rv, 32'hFFFF_FFFF);
    // Far below the advised storage period, so the run stays short
    wr(OFS_ON_TIME, 32'h2);
    wr(OFS_OFF_TIME, 32'h0);
    rd(OFS_ON_TIME);
    check("on time", rv, 32'h2);
    rd(OFS_OFF_TIME);
    check("off time", rv, 32'h0);
    gate_q <= 1'b1;
    setup(0, 2);
    cmd(start_clock_sync_acq);
    rd(OFS_ACQ_STAT);
    check("status", rv, STAT_TIMER_GATE);
    wait_samples(3);
    check("samples", s_t.size(), 3);
    for (int i = 1; i < 3; i++)
      check("period", s_c[i] - s_c[i-1], 2 * CYC_PER_US + OFF_ZERO_CYC);
    $display("Test clock sync done");

    // Gate held low must keep the counters shut even while the clock runs
    gate_q <= 1'b0;
    wr(OFS_ON_TIME, 32'h1);
    wr(OFS_OFF_TIME, 32'h1);
    setup(0, 50);
    cmd(start_clock_sync_acq);
    k = 0;
    repeat (50)
    begin
      @(posedge clk_in);
      k += (count_en === 1'b1);
    end
    check("gated off", k, 0);
    gate_q <= 1'b1;
    k = 0;
    while (count_en !== 1'b1 && k < 100)
    begin
      @(posedge clk_in);
      k++;
    end
    #1;
    check("count enable", {31'h0, count_en}, 32'h1);
    cmd(stop_acq);
    check("count enable", {31'h0, count_en}, 32'h0);
    k = s_t.size();
    repeat (100) @(posedge clk_in);
    check("samples", s_t.size(), k);
    rd(OFS_ACQ_STAT);
    check("status", rv, STAT_OFF);
    $display("Test stop done");
    wrap_up();
  end
endmodule : sync_counter_snapshot_acq_bench
